// *** test/right_shift_unit_bench.sv ***
// self-checking bench for the right shift unit
`timescale 1ns/1ps
`default_nettype none
`include "rsu_consts.svh"
module right_shift_unit_bench;
   import rsu_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic mode64 = 1'b1;
   logic req_valid;
   logic res_valid;
   logic illegal_instr;
   rsu_req_t req;
   rsu_res_t res;
   rsu_res_t expq[$];
   int fails = 0;
   int cmp_count = 0;
   logic [31:0] rng = 32'h0000D667;
   logic [31:0] opc [5] = '{`RSU_OPC_SRADI, `RSU_OPC_SRAW, `RSU_OPC_SRAWI,
      `RSU_OPC_SRD, `RSU_OPC_SRW};
   int cnt [7] = '{0, 1, 31, 32, 63, 64, 127};
   always #10 clk = ~clk;
   rsu_core #(.IS64(1'b1)) DUT (.clk(clk), .nrst(nrst), .ce(ce),
      .req_valid(req_valid), .req(req), .mode64(mode64),
      .res_valid(res_valid), .res(res), .illegal_instr(illegal_instr));
   rsu_feeder feed (.clk(clk), .req_valid(req_valid), .req(req));
   ////////////////////////////////////////////////////////////////////////
   // xorshift source, fixed seed so every run is the same
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // reference: k selects sradi, sraw, srawi, srd, srw
   function automatic rsu_res_t model(input int k, input rsu_req_t q);
      rsu_res_t r;
      logic [63:0] x;
      logic [6:0] n;
      r = '0;
      x = {{32{q.source_gpr[31]}}, q.source_gpr[31:0]};
      if (k == 0 || k == 3) x = q.source_gpr;
      if (k == 4) x[63:32] = 32'h0;
      n = {1'b0, q.amount_gpr[5:0]};
      if (k == 0) n = {1'b0, q.instr[1], q.instr[15:11]};
      if (k == 2) n = {2'b00, q.instr[15:11]};
      if (k == 3) n = q.amount_gpr[6:0];
      r.ca_write = (k < 3);
      if (k < 3) r.dest_gpr = $signed(x) >>> n;
      else r.dest_gpr = x >> n;
      // sign-extended word makes large counts lose sign bits too
      r.shift_out_flag = r.ca_write & x[63] & (|(x & ~({64{1'b1}} << n)));
      r.cr_write = q.instr[0];
      if (q.instr[0])
         r.first_condition_field = '{$signed(r.dest_gpr) < 0,
            $signed(r.dest_gpr) > 0, r.dest_gpr == 64'h0, q.so_in};
      return r;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // flags not written by an op are left out of the match
   task automatic cmp_res(input rsu_res_t e);
      rsu_res_t g;
      g = res;
      if (!e.ca_write) g.shift_out_flag = 1'b0;
      if (!e.cr_write) g.first_condition_field = '0;
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %0t res exp %h got %h", $time, e, g);
      end
   endtask
   task automatic cmp_flag(input logic g, input logic e);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %0t flag exp %h got %h", $time, e, g);
      end
   endtask
   task automatic issue(input int k, input logic [63:0] s,
      input logic [63:0] a, input logic [31:0] f);
      rsu_req_t r;
      r.instr = opc[k] | (f & ((k == 0) ? 32'h03FFF803 : 32'h03FFF801));
      r.source_gpr = s;
      r.amount_gpr = a;
      r.so_in = f[2];
      expq.push_back(model(k, r));
      feed.put(r);
   endtask
   // one idle slot: every result must be out by then
   task automatic drain;
      feed.idle(1);
      @(negedge clk);
      #1;
      cmp_flag(expq.size() == 0, 1'b1);
   endtask
   task automatic close_out;
      $display("counts: %0d compared, %0d failed", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // monitor: a strobe with nothing expected is a fault
   always @(negedge clk)
   begin
      if (nrst && illegal_instr)
         cmp_flag(illegal_instr, 1'b0);
      if (nrst && res_valid && expq.size() == 0)
         cmp_flag(res_valid, 1'b0);
      else if (nrst && res_valid)
         cmp_res(expq.pop_front());
   end
   // watchdog well beyond the expected run
   initial
   begin
      #80000;
      fails++;
      close_out;
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] f;
      logic [63:0] s;
      logic [63:0] a;
      repeat (12) @(posedge clk);
      #2;
      nrst = 1'b1;
      @(negedge clk);
      cmp_flag(res_valid | (|res), 1'b0);
      $display("test reset done");
      // boundary counts, both signs, back to back
      for (int k = 0; k < 5; k++)
         for (int c = 0; c < 7; c++)
            for (int sg = 0; sg < 2; sg++)
            begin
               f = rnd();
               f[15:11] = cnt[c][4:0];
               f[1] = cnt[c][5];
               s = {rnd(), rnd()};
               s[63] = sg[0];
               s[31] = sg[0];
               a = {rnd(), rnd()};
               a[6:0] = cnt[c][6:0];
               issue(k, s, a, f);
            end
      drain;
      $display("test boundary counts done");
      // unknown opcode and frozen clock enable give no result
      feed.put('{32'h7C000678, 64'h1, 64'h1, 1'b0});
      feed.idle(1);
      ce = 1'b0;
      feed.put('{`RSU_OPC_SRW, 64'h1, 64'h1, 1'b0});
      feed.idle(2);
      ce = 1'b1;
      drain;
      $display("test refusal done");
      // random mix with mode flips and slow issue gaps
      repeat (300)
      begin
         f = rnd();
         mode64 = f[8];
         issue(f % 5, {rnd(), rnd()}, {rnd(), rnd()}, f);
         if (f[10:9] == 2'b11) feed.idle(1);
      end
      drain;
      $display("test random done");
      nrst = 1'b0;
      @(negedge clk);
      cmp_flag(res_valid | (|res), 1'b0);
      $display("test mid reset done");
      close_out;
   end
endmodule
`default_nettype wire

// *** test/rsu_feeder.sv ***
// decode and dispatch model that feeds operands to the right shift unit
`timescale 1ns/1ps
`default_nettype none
module rsu_feeder
(
   input wire logic clk, // core clock
   output logic req_valid, // operands presented
   output rsu_pkg::rsu_req_t req // instruction and operands
);
   import rsu_pkg::*;
   initial
   begin
      req_valid = 1'b0;
      req = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   // one instruction a cycle, changed only just after an edge
   task automatic put(input rsu_req_t r);
      @(posedge clk);
      #2;
      req_valid = 1'b1;
      req = r;
   endtask
   // idle slots: operand buses carry garbage, so stale values never help
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge clk);
         #2;
         req_valid = 1'b0;
         req = ~req;
      end
   endtask
endmodule
`default_nettype wire

// *** verilog/rsu_consts.svh ***
// constants for the right shift unit: opcodes, field positions, resets
`ifndef RSU_CONSTS_SVH
`define RSU_CONSTS_SVH
`define RSU_OPC_SRADI 32'h7C000674
`define RSU_OPC_SRAW 32'h7C000630
`define RSU_OPC_SRAWI 32'h7C000670
`define RSU_OPC_SRD 32'h7C000436
`define RSU_OPC_SRW 32'h7C000430
`define RSU_MASK_X 32'hFC0007FE
`define RSU_MASK_XS 32'hFC0007FC
`define RSU_XO_SRD 10'h21B
`define RSU_XO_SRW 10'h218
`define RSU_SH_LO_MSB 15
`define RSU_SH_LO_LSB 11
`define RSU_SH_HI_BIT 1
`define RSU_REC_BIT 0
`define RSU_XO_MSB 10
`define RSU_XO_LSB 1
`define RSU_CR_RESET 4'h0
`define RSU_CA_RESET 1'b0
`endif

// *** verilog/rsu_core.sv ***
// right shift execution datapath: decode, shift, carry and condition field
//
// Functional notes
// - decode doubleword immediate arithmetic shift opcode
// - immediate count msb is split field bit
// - doubleword arithmetic shift fills with sign
// - carry set when negative and ones lost
// - zero count copies source, clears carry
// - carry identical in 32 and 64-bit mode
// - decode word shift by register, six bits
// - word count 32..63 gives all sign bits
// - large word count loads carry with sign
// - decode word immediate shift, sign extend
// - word carry from negative low half losing ones
// - zero word count sign extends, clears carry
// - decode logical doubleword right shift
// - doubleword logical counts 64..127 give zero
// - decode logical word shift, zero fill
// - word logical clears top, big counts zero
// - record bit updates condition field
// - 32-bit part flags doubleword ops illegal
`timescale 1ns/1ps
`default_nettype none
`include "rsu_consts.svh"
module rsu_core
#(
   parameter bit IS64 = 1'b1
)
(
   input wire logic clk, // 50 MHz core clock
   input wire logic nrst, // async reset, active low
   input wire logic ce, // clock enable, freezes all state
   input wire logic req_valid, // operands presented this cycle
   input wire rsu_pkg::rsu_req_t req, // instruction and operands
   input wire logic mode64, // core runs in 64-bit mode
   output logic res_valid, // result strobe, one cycle
   output rsu_pkg::rsu_res_t res, // result bundle
   output logic illegal_instr // illegal-instruction pulse
);
   import rsu_pkg::*;
   rsu_op_t op;
   logic dec_illegal;
   logic [5:0] imm_count;
   logic [6:0] count;
   logic [63:0] sh_in;
   logic fill;
   logic [63:0] sh_out;
   logic lost;
   logic [63:0] next_dest;
   logic next_ca;
   logic next_ca_write;
   logic record;
   logic is_shift;
   ////////////////////////////////////////////////////////////////////////
   // decode
   rsu_decode u_dec
   (
      .instr(req.instr),
      .is64(IS64),
      .op(op),
      .illegal(dec_illegal)
   );
   assign record = req.instr[`RSU_REC_BIT];
   assign is_shift = req_valid && (op != RSU_OP_NONE);
   // split immediate: high bit sits apart from the five low bits
   assign imm_count = {req.instr[`RSU_SH_HI_BIT],
                       req.instr[`RSU_SH_LO_MSB:`RSU_SH_LO_LSB]};
   ////////////////////////////////////////////////////////////////////////
   // operand and count selection per operation
   always_comb
   begin
      count = 7'h00;
      sh_in = req.source_gpr;
      fill = 1'b0;
      case (op)
         RSU_OP_SRADI:
         begin
            count = {1'b0, imm_count};
            fill = req.source_gpr[63];
         end
         RSU_OP_SRAW:
         begin
            // bit 5 of the count gives 32..63; the sign-extended input turns these into all sign bits
            count = {1'b0, req.amount_gpr[5:0]};
            sh_in = {{32{req.source_gpr[31]}}, req.source_gpr[31:0]};
            fill = req.source_gpr[31];
         end
         RSU_OP_SRAWI:
         begin
            count = {2'b00, imm_count[4:0]};
            sh_in = {{32{req.source_gpr[31]}}, req.source_gpr[31:0]};
            fill = req.source_gpr[31];
         end
         RSU_OP_SRD:
            count = req.amount_gpr[6:0];
         RSU_OP_SRW:
         begin
            count = {1'b0, req.amount_gpr[5:0]};
            sh_in = {32'h00000000, req.source_gpr[31:0]};
         end
         default:
            count = 7'h00;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   // shared barrel shifter
   rsu_shift #(.WIDTH(64)) u_shf
   (
      .din(sh_in),
      .count(count),
      .fill(fill),
      .dout(sh_out),
      .lost_one(lost)
   );
   ////////////////////////////////////////////////////////////////////////
   // result and carry; mode64 deliberately plays no part in the carry
   always_comb
   begin
      next_dest = sh_out;
      next_ca = 1'b0;
      next_ca_write = 1'b0;
      case (op)
         RSU_OP_SRADI:
         begin
            // zero count loses nothing, so carry clears by itself
            next_ca = fill & lost;
            next_ca_write = 1'b1;
         end
         RSU_OP_SRAW, RSU_OP_SRAWI:
         begin
            // lost ones in the 64-bit image include the upper sign copies
            // only for count >= 32, where carry equals the sign anyway
            next_ca = fill & lost;
            next_ca_write = 1'b1;
         end
         default:
            next_ca = 1'b0;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   // output registers, single cycle
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         res_valid <= 1'b0;
         illegal_instr <= 1'b0;
      end
      else if (ce)
      begin
         res_valid <= is_shift;
         illegal_instr <= req_valid && dec_illegal;
      end
   end
   // result bundle in one process: one writer for the whole struct
   // condition field: signed compare of the full 64-bit destination
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         res.dest_gpr <= 64'h0000000000000000;
         res.shift_out_flag <= `RSU_CA_RESET;
         res.ca_write <= 1'b0;
         res.cr_write <= 1'b0;
         res.first_condition_field <= `RSU_CR_RESET;
      end
      else if (ce && is_shift)
      begin
         res.dest_gpr <= next_dest;
         res.shift_out_flag <= next_ca;
         res.ca_write <= next_ca_write;
         res.cr_write <= record;
         res.first_condition_field.negative_bit <= next_dest[63];
         res.first_condition_field.positive_bit <=
            !next_dest[63] && (next_dest != 64'h0000000000000000);
         res.first_condition_field.zero_bit <=
            (next_dest == 64'h0000000000000000);
         res.first_condition_field.summary_ovf <= req.so_in;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // checks
   logic unused_mode;
   assign unused_mode = mode64;
   chk_valid_latency: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && is_shift |=> res_valid)
      else $error("result strobe missing");
   chk_sradi_zero: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRADI && imm_count == 6'h00
      |=> res.dest_gpr == $past(req.source_gpr) && !res.shift_out_flag)
      else $error("zero count sradi wrong");
   chk_srd_big: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRD && req.amount_gpr[6]
      |=> res.dest_gpr == 64'h0000000000000000)
      else $error("big srd not zero");
   chk_srw_upper: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRW
      |=> res.dest_gpr[63:32] == 32'h00000000)
      else $error("srw upper not clear");
   chk_sraw_big: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRAW && req.amount_gpr[5]
      |=> res.dest_gpr == {64{$past(req.source_gpr[31])}}
          && res.shift_out_flag == $past(req.source_gpr[31]))
      else $error("large sraw wrong");
   chk_ca_positive: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && is_shift && fill == 1'b0 |=> !res.shift_out_flag)
      else $error("carry set on positive");
   chk_srawi_ext: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRAWI
      |=> res.dest_gpr[63:31] == {33{res.dest_gpr[31]}})
      else $error("srawi not extended");
   chk_illegal_32: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && req_valid && dec_illegal |=> illegal_instr && !res_valid)
      else $error("illegal op not flagged");
   chk_cr_zero: assert property (
      @(posedge clk) disable iff (!nrst)
      res_valid && res.cr_write
      |-> res.first_condition_field.zero_bit
          == (res.dest_gpr == 64'h0000000000000000))
      else $error("zero bit mismatch");
   // carry worked out from the source and mask, not from the shifter
   chk_sradi_carry: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRADI
      |=> res.shift_out_flag == ($past(req.source_gpr[63])
          && (($past(req.source_gpr) & ~({64{1'b1}} << $past(imm_count)))
          != 64'h0000000000000000)))
      else $error("sradi carry wrong");
   chk_sradi_fill: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRADI
      |=> res.dest_gpr
          == 64'($signed($past(req.source_gpr)) >>> $past(imm_count)))
      else $error("sradi result wrong");
   chk_word_zero: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && is_shift && (op == RSU_OP_SRAW || op == RSU_OP_SRAWI)
      && count == 7'h00
      |=> res.dest_gpr == {{32{$past(req.source_gpr[31])}},
                           $past(req.source_gpr[31:0])}
          && !res.shift_out_flag)
      else $error("zero count word shift wrong");
   // decode: the record bit and register fields must not spoil a match
   chk_srd_decode: assert property (
      @(posedge clk) disable iff (!nrst)
      IS64 && (req.instr & `RSU_MASK_X) == `RSU_OPC_SRD
      |-> op == RSU_OP_SRD)
      else $error("srd not decoded");
   chk_srw_decode: assert property (
      @(posedge clk) disable iff (!nrst)
      (req.instr & `RSU_MASK_X) == `RSU_OPC_SRW |-> op == RSU_OP_SRW)
      else $error("srw not decoded");
   // unknown opcodes must leave no strobe behind
   chk_none_silent: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && req_valid && op == RSU_OP_NONE && !dec_illegal
      |=> !res_valid)
      else $error("strobe on unknown opcode");
   // a low enable must hold every output where it stands
   chk_ce_freeze: assert property (
      @(posedge clk) disable iff (!nrst)
      !ce |=> $stable(res) && $stable(res_valid) && $stable(illegal_instr))
      else $error("state moved with enable low");
   cov_sradi: cover property (@(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRADI && next_ca);
   cov_sraw_big: cover property (@(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRAW && req.amount_gpr[5]);
   cov_srd: cover property (@(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRD && record);
   cov_srw: cover property (@(posedge clk) disable iff (!nrst)
      ce && is_shift && op == RSU_OP_SRW);
endmodule
`default_nettype wire

// *** verilog/rsu_decode.sv ***
// opcode decoder for the right shift unit
`timescale 1ns/1ps
`default_nettype none
`include "rsu_consts.svh"
module rsu_decode
(
   input wire logic [31:0] instr, // instruction word
   input wire logic is64, // 64-bit implementation
   output rsu_pkg::rsu_op_t op, // decoded operation
   output logic illegal // doubleword op on 32-bit part
);
   import rsu_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   // match on primary and extended opcode, record bit ignored
   always_comb
   begin
      op = RSU_OP_NONE;
      illegal = 1'b0;
      if ((instr & `RSU_MASK_XS) == (`RSU_OPC_SRADI & `RSU_MASK_XS))
      begin
         op = is64 ? RSU_OP_SRADI : RSU_OP_NONE;
         illegal = !is64;
      end
      else if ((instr & `RSU_MASK_X) == `RSU_OPC_SRAW)
         op = RSU_OP_SRAW;
      else if ((instr & `RSU_MASK_X) == `RSU_OPC_SRAWI)
         op = RSU_OP_SRAWI;
      else if ((instr & `RSU_MASK_X) == `RSU_OPC_SRD)
      begin
         op = is64 ? RSU_OP_SRD : RSU_OP_NONE;
         illegal = !is64;
      end
      else if ((instr & `RSU_MASK_X) == `RSU_OPC_SRW)
         op = RSU_OP_SRW;
   end
endmodule
`default_nettype wire

// *** verilog/rsu_pkg.sv ***
// types for the right shift unit
package rsu_pkg;
   typedef enum logic [5:0]
   {
      RSU_OP_NONE = 6'h01,
      RSU_OP_SRADI = 6'h02,
      RSU_OP_SRAW = 6'h04,
      RSU_OP_SRAWI = 6'h08,
      RSU_OP_SRD = 6'h10,
      RSU_OP_SRW = 6'h20
   } rsu_op_t;
   typedef struct packed
   {
      logic negative_bit;
      logic positive_bit;
      logic zero_bit;
      logic summary_ovf;
   } rsu_cr_t;
   typedef struct packed
   {
      logic [31:0] instr;
      logic [63:0] source_gpr;
      logic [63:0] amount_gpr;
      logic so_in;
   } rsu_req_t;
   typedef struct packed
   {
      logic [63:0] dest_gpr;
      logic shift_out_flag;
      logic ca_write;
      logic cr_write;
      rsu_cr_t first_condition_field;
   } rsu_res_t;
endpackage

// *** verilog/rsu_shift.sv ***
// combinational sign/zero filling right shifter with shifted-out detect
`timescale 1ns/1ps
`default_nettype none
module rsu_shift
#(
   parameter int WIDTH = 64
)
(
   input wire logic [WIDTH-1:0] din, // value to shift
   input wire logic [6:0] count, // shift count, saturates at WIDTH
   input wire logic fill, // bit shifted in at the top
   output logic [WIDTH-1:0] dout, // shifted value
   output logic lost_one // a 1 bit left the bottom
);
   logic [2*WIDTH-1:0] wide;
   // a third width of zeros catches the bits that leave the bottom
   logic [3*WIDTH-1:0] moved;
   ////////////////////////////////////////////////////////////////////////
   // triple width shift keeps the lost bits for the carry check
   always_comb
   begin
      wide = {{WIDTH{fill}}, din};
      moved = {wide, {WIDTH{1'b0}}} >> count;
      if (count >= 7'(WIDTH))
      begin
         dout = {WIDTH{fill}};
         lost_one = |din;
      end
      else
      begin
         dout = moved[2*WIDTH-1:WIDTH];
         lost_one = |moved[WIDTH-1:0];
      end
   end
endmodule
`default_nettype wire
